// ### logic/calib_hist_pkg.sv
package calib_hist_pkg;
   localparam int BYTE_W = 8;
   localparam logic [7:0] APP_MAIN = 8'h03;
   localparam logic [7:0] PAGE_CALIB = 8'h19;
   localparam logic [7:0] PAGE_HIST = 8'h81;
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] CAL_FIRST_OFS = 8'h24;
   localparam logic [7:0] CAL_COPY_OFS = 8'hdc;
   localparam logic [7:0] CAL_LAST_OFS = 8'hdf;
   localparam int CAL_DEPTH = 188;
   localparam int CAL_AW = 8;
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] HIST_NUM_OFS = 8'h24;
   localparam logic [7:0] HIST_SIZE_OFS = 8'h25;
   localparam logic [7:0] HIST_SLOT_OFS = 8'h26;
   localparam logic [7:0] HIST_FIRST_OFS = 8'h27;
   localparam logic [7:0] HIST_LAST_OFS = 8'ha6;
   localparam int HIST_DEPTH = 128;
   localparam int HIST_AW = 7;
   localparam int SLOT_BIT = 0;
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] HIST_SIZE_VAL = 8'h80;
   localparam logic [7:0] NUM_RST = 8'h00;
   localparam logic [7:0] SLOT_RST = 8'h00;
   localparam logic [7:0] COPY_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] CAL_OK = 8'h00;
endpackage : calib_hist_pkg

// ### logic/page_ram.sv
`timescale 1ns/1ps
module page_ram #(
   parameter int DEPTH = 128,
   parameter int AW = 7,
   parameter int DW = 8
) (
   // clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // read port
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata,
   output logic busy
);
   import calib_hist_pkg::*;
   logic [DW-1:0] mem [DEPTH];
   logic [AW-1:0] clr_reg;
   logic busy_reg;
   logic [DW-1:0] rdata_reg;
   assign rdata = rdata_reg;
   assign busy = busy_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // contents cannot reset at once, so a sweep writes the reset value after reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clr_reg <= '0;
         busy_reg <= 1'b1;
      end else if (en && busy_reg) begin
         clr_reg <= clr_reg + 1'b1;
         if (clr_reg == AW'(DEPTH - 1)) begin
            busy_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (en) begin
         if (busy_reg) begin
            mem[clr_reg] <= DW'(DATA_RST);
         end else if (we) begin
            mem[waddr] <= wdata;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (en) begin
         if (busy_reg) begin
            rdata_reg <= '0;
         end else if (re) begin
            rdata_reg <= mem[raddr];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_ram_readback: assert property (@(posedge clk) disable iff (!rst_n)
      (en && we && !busy) ##1 (en && re && !we && !busy && raddr == $past(waddr))
      |=> rdata == $past(wdata, 2))
      else $error("byte read back differs from byte written");
endmodule : page_ram

// ### logic/page_decode.sv
`timescale 1ns/1ps
module page_decode (
   // page selection
   input wire logic [7:0] app_id,
   input wire logic [7:0] page_id,
   input wire logic [7:0] addr,
   // page hits
   output logic calib_on,
   output logic hist_on,
   // region hits
   output logic cal_ram_hit,
   output logic cal_copy_hit,
   output logic h_num_hit,
   output logic h_size_hit,
   output logic h_slot_hit,
   output logic h_ram_hit,
   // memory indices
   output logic [calib_hist_pkg::CAL_AW-1:0] cal_idx,
   output logic [calib_hist_pkg::HIST_AW-1:0] h_idx
);
   import calib_hist_pkg::*;
   logic [7:0] cal_diff;
   logic [7:0] h_diff;
   always_comb begin
      calib_on = (app_id == APP_MAIN) && (page_id == PAGE_CALIB);
      hist_on = (app_id == APP_MAIN) && (page_id == PAGE_HIST);
      cal_diff = addr - CAL_FIRST_OFS;
      h_diff = addr - HIST_FIRST_OFS;
      cal_idx = cal_diff;
      h_idx = h_diff[HIST_AW-1:0];
      // the status copy byte lives in a flop, the rest of the block in memory
      cal_copy_hit = calib_on && (addr == CAL_COPY_OFS);
      cal_ram_hit = calib_on && (addr >= CAL_FIRST_OFS) && (addr <= CAL_LAST_OFS)
         && !cal_copy_hit;
      h_num_hit = hist_on && (addr == HIST_NUM_OFS);
      h_size_hit = hist_on && (addr == HIST_SIZE_OFS);
      h_slot_hit = hist_on && (addr == HIST_SLOT_OFS);
      h_ram_hit = hist_on && (addr >= HIST_FIRST_OFS) && (addr <= HIST_LAST_OFS);
   end
endmodule : page_decode

// ### logic/calib_histogram_pages.sv
`timescale 1ns/1ps
module calib_histogram_pages (
   // clock, reset, enable
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CE,
   // page selection from the main application registers
   input wire logic [calib_hist_pkg::BYTE_W-1:0] APP_ID,
   input wire logic [calib_hist_pkg::BYTE_W-1:0] PAGE_ID,
   // host byte register port
   input wire logic [calib_hist_pkg::BYTE_W-1:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [calib_hist_pkg::BYTE_W-1:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [calib_hist_pkg::BYTE_W-1:0] REG_RDATA,
   output logic REG_RVALID,
   output logic INIT_BUSY,
   // factory calibration status source
   input wire logic CAL_ACTIVE,
   input wire logic [calib_hist_pkg::BYTE_W-1:0] CAL_STATUS,
   // histogram producer
   input wire logic HIST_WE,
   input wire logic [calib_hist_pkg::HIST_AW-1:0] HIST_IDX,
   input wire logic [calib_hist_pkg::BYTE_W-1:0] HIST_WDATA,
   input wire logic HIST_COMMIT,
   input wire logic [calib_hist_pkg::BYTE_W-1:0] HIST_NUM,
   input wire logic HIST_SLOT,
   output logic HIST_LAST_READ
);
   import calib_hist_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // decode

   logic calib_on;
   logic hist_on;
   logic cal_ram_hit;
   logic cal_copy_hit;
   logic h_num_hit;
   logic h_size_hit;
   logic h_slot_hit;
   logic h_ram_hit;
   logic [CAL_AW-1:0] cal_idx;
   logic [HIST_AW-1:0] h_idx;

   page_decode u_decode (
      .app_id(APP_ID),
      .page_id(PAGE_ID),
      .addr(REG_ADDR),
      .calib_on(calib_on),
      .hist_on(hist_on),
      .cal_ram_hit(cal_ram_hit),
      .cal_copy_hit(cal_copy_hit),
      .h_num_hit(h_num_hit),
      .h_size_hit(h_size_hit),
      .h_slot_hit(h_slot_hit),
      .h_ram_hit(h_ram_hit),
      .cal_idx(cal_idx),
      .h_idx(h_idx)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // calibration block memory

   logic [BYTE_W-1:0] cal_rdata;
   logic cal_busy;
   logic cal_we;
   logic cal_re;

   assign cal_we = REG_WR && cal_ram_hit;
   assign cal_re = REG_RD && cal_ram_hit;

   page_ram #(
      .DEPTH(CAL_DEPTH),
      .AW(CAL_AW),
      .DW(BYTE_W)
   ) u_cal_ram (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .en(CE),
      .we(cal_we),
      .waddr(cal_idx),
      .wdata(REG_WDATA),
      .re(cal_re),
      .raddr(cal_idx),
      .rdata(cal_rdata),
      .busy(cal_busy)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // histogram data memory

   logic [BYTE_W-1:0] h_rdata;
   logic h_busy;
   logic h_we;
   logic h_re;
   logic [HIST_AW-1:0] h_waddr;
   logic [BYTE_W-1:0] h_wdata;

   // one write port: the producer wins, a host write in that same cycle is dropped
   always_comb begin
      h_we = HIST_WE || (REG_WR && h_ram_hit);
      h_waddr = HIST_WE ? HIST_IDX : h_idx;
      h_wdata = HIST_WE ? HIST_WDATA : REG_WDATA;
   end
   assign h_re = REG_RD && h_ram_hit;

   page_ram #(
      .DEPTH(HIST_DEPTH),
      .AW(HIST_AW),
      .DW(BYTE_W)
   ) u_hist_ram (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .en(CE),
      .we(h_we),
      .waddr(h_waddr),
      .wdata(h_wdata),
      .re(h_re),
      .raddr(h_idx),
      .rdata(h_rdata),
      .busy(h_busy)
   );

   assign INIT_BUSY = cal_busy || h_busy;

   ////////////////////////////////////////////////////////////////////////////////
   // calibration status copy

   logic [BYTE_W-1:0] copy_reg;

   // the live status copy beats a host write in the same cycle
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         copy_reg <= COPY_RST;
      end else if (CE) begin
         if (CAL_ACTIVE) begin
            copy_reg <= CAL_STATUS;
         end else if (REG_WR && cal_copy_hit) begin
            copy_reg <= REG_WDATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // histogram header bytes

   logic [BYTE_W-1:0] num_reg;
   logic slot_reg;

   // a producer commit wins over a host write so a new subpacket is never lost
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         num_reg <= NUM_RST;
      end else if (CE) begin
         if (HIST_COMMIT) begin
            num_reg <= HIST_NUM;
         end else if (REG_WR && h_num_hit) begin
            num_reg <= REG_WDATA;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         slot_reg <= SLOT_RST[SLOT_BIT];
      end else if (CE) begin
         if (HIST_COMMIT) begin
            slot_reg <= HIST_SLOT;
         end else if (REG_WR && h_slot_hit) begin
            slot_reg <= REG_WDATA[SLOT_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read pipeline, stage one: pick source, capture header value

   logic rd_q1;
   logic cal_q1;
   logic hist_q1;
   logic ram_cal_q1;
   logic ram_h_q1;
   logic [BYTE_W-1:0] addr_q1;
   logic [BYTE_W-1:0] hdr_q1;
   logic [BYTE_W-1:0] hdr_next;

   // size writes are accepted and ignored: the byte is a constant
   always_comb begin
      hdr_next = '0;
      if (cal_copy_hit) begin
         hdr_next = copy_reg;
      end else if (h_num_hit) begin
         hdr_next = num_reg;
      end else if (h_size_hit) begin
         hdr_next = HIST_SIZE_VAL;
      end else if (h_slot_hit) begin
         hdr_next = {7'h00, slot_reg};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         rd_q1 <= 1'b0;
         cal_q1 <= 1'b0;
         hist_q1 <= 1'b0;
         ram_cal_q1 <= 1'b0;
         ram_h_q1 <= 1'b0;
         addr_q1 <= '0;
         hdr_q1 <= '0;
      end else if (CE) begin
         rd_q1 <= REG_RD;
         cal_q1 <= calib_on;
         hist_q1 <= hist_on;
         ram_cal_q1 <= cal_re;
         ram_h_q1 <= h_re;
         addr_q1 <= REG_ADDR;
         hdr_q1 <= hdr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read pipeline, stage two: registered answer

   logic rvalid_reg;
   logic [BYTE_W-1:0] rdata_reg;
   logic last_reg;
   logic cal_q2;
   logic hist_q2;
   logic [BYTE_W-1:0] addr_q2;

   // unselected pages and unmapped offsets answer zero
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
      end else if (CE) begin
         rvalid_reg <= rd_q1;
         if (ram_cal_q1) begin
            rdata_reg <= cal_rdata;
         end else if (ram_h_q1) begin
            rdata_reg <= h_rdata;
         end else begin
            rdata_reg <= hdr_q1;
         end
      end
   end

   // marks the end of a subpacket read so the producer may present the next one
   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         last_reg <= 1'b0;
      end else if (CE) begin
         last_reg <= rd_q1 && hist_q1 && (addr_q1 == HIST_LAST_OFS);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         cal_q2 <= 1'b0;
         hist_q2 <= 1'b0;
         addr_q2 <= '0;
      end else if (CE) begin
         cal_q2 <= cal_q1;
         hist_q2 <= hist_q1;
         addr_q2 <= addr_q1;
      end
   end

   assign REG_RVALID = rvalid_reg;
   assign REG_RDATA = rdata_reg;
   assign HIST_LAST_READ = last_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   a_page_gate: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      REG_RVALID && !cal_q2 && !hist_q2 |-> REG_RDATA == 8'h00)
      else $error("unselected page returned nonzero data");

   a_payload_const: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      REG_RVALID && hist_q2 && addr_q2 == HIST_SIZE_OFS |-> REG_RDATA == 8'h80)
      else $error("payload size byte not 0x80");

   a_slot_upper: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      REG_RVALID && hist_q2 && addr_q2 == HIST_SLOT_OFS |-> REG_RDATA[7:1] == 7'h00)
      else $error("config byte upper bits not zero");

   a_slot_commit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && HIST_COMMIT |=> slot_reg == $past(HIST_SLOT))
      else $error("timeslot bit not taken from commit");

   a_copy_status: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && CAL_ACTIVE |=> copy_reg == $past(CAL_STATUS))
      else $error("status copy not updated");

   a_index_commit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && HIST_COMMIT |=> num_reg == $past(HIST_NUM))
      else $error("subpacket number not taken from commit");

   a_data_window: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      REG_RVALID && hist_q2 && addr_q2 > HIST_LAST_OFS |-> REG_RDATA == 8'h00)
      else $error("byte above last data offset not zero");

   a_cal_window: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      REG_RVALID && cal_q2 && addr_q2 < CAL_FIRST_OFS |-> REG_RDATA == 8'h00)
      else $error("byte below calibration block not zero");

   a_read_latency: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      (CE && REG_RD) ##1 CE |=> REG_RVALID)
      else $error("read answer not two enabled cycles later");

   c_cal_read: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
      REG_RVALID && cal_q2 && addr_q2 == CAL_COPY_OFS);
   c_last_read: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
      HIST_LAST_READ);
   c_commit: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && HIST_COMMIT ##1 CE && REG_RD && h_num_hit);
   c_cal_fail: cover property (@(posedge CLK_SYS) disable iff (!RESETN)
      CE && CAL_ACTIVE && CAL_STATUS != CAL_OK);

endmodule : calib_histogram_pages

// ### bench/host_model.sv
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic clk,
   // byte register port toward the device
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic last_read
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      // released lines must not keep showing the old value
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr_byte
   ////////////////////////////////////////////////////////////////////////////////
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic got,
                          output logic last);
      int n;
      d = 8'h00;
      got = 1'b0;
      last = 1'b0;
      @(posedge clk);
      #1;
      reg_rd = 1'b1;
      reg_wr = 1'b0;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      n = 0;
      while (!got && n < 4) begin
         @(posedge clk);
         #1;
         if (reg_rvalid === 1'b1) begin
            got = 1'b1;
            d = reg_rdata;
            last = last_read;
         end
         n++;
      end
   endtask : rd_byte
   ////////////////////////////////////////////////////////////////////////////////
   // write taken on one edge, read of the same byte taken on the very next edge
   task automatic wr_rd_byte(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                             output logic got);
      logic l;
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      rd_byte(a, q, got, l);
      reg_wdata = ~d;
   endtask : wr_rd_byte
   ////////////////////////////////////////////////////////////////////////////////
   // a whole subpacket is read in one pass before the next one is let in
   task automatic read_packet(output logic [7:0] pkt [0:130], output logic [130:0] lastv,
                              output logic all_got);
      logic g;
      all_got = 1'b1;
      for (int k = 0; k < 131; k++) begin
         rd_byte(8'h24 + k[7:0], pkt[k], g, lastv[k]);
         all_got = all_got & g;
      end
   endtask : read_packet
endmodule : host_model

// ### bench/tb_calib_histogram_pages.sv
`timescale 1ns/1ps
module tb_calib_histogram_pages;
   import calib_hist_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] app_id = 8'h00;
   logic [7:0] page_id = 8'h00;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, hist_wdata, hist_num;
   logic reg_wr, reg_rd, reg_rvalid, init_busy, last_read;
   logic cal_active = 1'b0;
   logic [7:0] cal_status = 8'h00;
   logic hist_we = 1'b0;
   logic [6:0] hist_idx = 7'h00;
   logic hist_commit = 1'b0;
   logic hist_slot = 1'b0;
   logic ce = 1'b1;
   logic [7:0] pkt [0:130];
   logic [130:0] lastv;
   logic all_got;
   int num_errors = 0;
   int num_checks = 0;
   initial hist_wdata = 8'h00;
   initial hist_num = 8'h00;
   always #2.5 clk = ~clk;
   calib_histogram_pages dut (.CLK_SYS(clk), .RESETN(rstn), .CE(ce), .APP_ID(app_id),
      .PAGE_ID(page_id), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .INIT_BUSY(init_busy),
      .CAL_ACTIVE(cal_active), .CAL_STATUS(cal_status), .HIST_WE(hist_we), .HIST_IDX(hist_idx),
      .HIST_WDATA(hist_wdata), .HIST_COMMIT(hist_commit), .HIST_NUM(hist_num),
      .HIST_SLOT(hist_slot), .HIST_LAST_READ(last_read));
   host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .last_read(last_read));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic g, l;
      host.rd_byte(a, d, g, l);
      check({7'h00, g}, 8'h01);
      check(d, exp);
   endtask : rchk
   task automatic wrchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic g;
      host.wr_rd_byte(a, exp, d, g);
      check({7'h00, g}, 8'h01);
      check(d, exp);
   endtask : wrchk
   task automatic set_page(input logic [7:0] a, input logic [7:0] p);
      app_id = a;
      page_id = p;
   endtask : set_page
   function automatic logic [7:0] pat(input int i, input logic [7:0] num);
      return i[7:0] * 8'h07 + num;
   endfunction : pat
   ////////////////////////////////////////////////////////////////////////////////
   task automatic do_reset;
      int n;
      rstn = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check(reg_rdata, 8'h00);
      check({6'h00, reg_rvalid, last_read}, 8'h00);
      check({7'h00, init_busy}, 8'h01);
      rstn = 1'b1;
      n = 0;
      // the zero sweep takes 188 cycles; 300 leaves margin without hiding a hang
      while (init_busy !== 1'b0 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({7'h00, init_busy}, 8'h00);
   endtask : do_reset
   task automatic load_packet(input logic [7:0] num, input logic slot);
      for (int i = 0; i < 128; i++) begin
         @(posedge clk);
         #1;
         hist_we = 1'b1;
         hist_idx = i[6:0];
         hist_wdata = pat(i, num);
      end
      @(posedge clk);
      #1;
      hist_we = 1'b0;
      hist_idx = 7'h55;
      hist_wdata = ~hist_wdata;
      hist_commit = 1'b1;
      hist_num = num;
      hist_slot = slot;
      @(posedge clk);
      #1;
      hist_commit = 1'b0;
      hist_num = ~num;
      hist_slot = ~slot;
   endtask : load_packet
   task automatic check_packet(input logic [7:0] num, input logic slot);
      host.read_packet(pkt, lastv, all_got);
      check({7'h00, all_got}, 8'h01);
      check(pkt[0], num);
      check(pkt[1], HIST_SIZE_VAL);
      check(pkt[2], {7'h00, slot});
      for (int k = 0; k < 128; k++) begin
         check(pkt[k + 3], pat(k, num));
         check({7'h00, lastv[k + 3]}, {7'h00, k == 127});
      end
   endtask : check_packet
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      num_errors++;
      stop_test();
   end
   initial begin
      do_reset();
      set_page(APP_MAIN, PAGE_HIST);
      rchk(8'h24, NUM_RST);
      rchk(8'h25, HIST_SIZE_VAL);
      rchk(8'h26, SLOT_RST);
      rchk(8'h27, DATA_RST);
      rchk(8'ha6, DATA_RST);
      rchk(8'hb0, 8'h00);
      set_page(APP_MAIN, PAGE_CALIB);
      rchk(8'h24, DATA_RST);
      rchk(8'hdc, COPY_RST);
      rchk(8'hdf, DATA_RST);
      for (int a = 'h24; a <= 'hdf; a++) host.wr_byte(a[7:0], a[7:0] ^ 8'h5a);
      for (int a = 'h24; a <= 'hdf; a++) rchk(a[7:0], a[7:0] ^ 8'h5a);
      wrchk(8'h80, 8'ha5);
      rchk(8'h23, 8'h00);
      rchk(8'he0, 8'h00);
      set_page(8'h02, PAGE_CALIB);
      host.wr_byte(8'h24, 8'h11);
      rchk(8'h25, 8'h00);
      set_page(APP_MAIN, 8'h18);
      rchk(8'h30, 8'h00);
      set_page(APP_MAIN, PAGE_HIST);
      rchk(8'h27, 8'h00);
      set_page(APP_MAIN, PAGE_CALIB);
      rchk(8'h24, 8'h24 ^ 8'h5a);
      cal_status = 8'h3c;
      cal_active = 1'b1;
      rchk(8'hdc, 8'h3c);
      cal_status = CAL_OK;
      rchk(8'hdc, CAL_OK);
      cal_active = 1'b0;
      cal_status = 8'hc3;
      rchk(8'hdc, CAL_OK);
      set_page(APP_MAIN, PAGE_HIST);
      load_packet(8'h05, 1'b1);
      check_packet(8'h05, 1'b1);
      load_packet(8'h06, 1'b0);
      check_packet(8'h06, 1'b0);
      wrchk(8'h50, 8'h3c);
      host.wr_byte(8'h25, 8'h11);
      rchk(8'h25, HIST_SIZE_VAL);
      host.wr_byte(8'h26, 8'hff);
      rchk(8'h26, 8'h01);
      host.wr_byte(8'h24, 8'h42);
      rchk(8'h24, 8'h42);
      // a write while the enable is low must leave no trace
      ce = 1'b0;
      host.wr_byte(8'h24, 8'h99);
      ce = 1'b1;
      rchk(8'h24, 8'h42);
      do_reset();
      rchk(8'h24, NUM_RST);
      rchk(8'h26, SLOT_RST);
      rchk(8'ha6, DATA_RST);
      stop_test();
   end
endmodule : tb_calib_histogram_pages
